// >>> rtl/hss_fault_pkg.sv
// constants and state types shared by the switch fault protection logic
// assumes a single 125 MHz core clock and a synchronous active-low reset
package hss_fault_pkg;

  // =========================================================================
  // timing
  localparam int CLK_PERIOD_NS   = 8;
  localparam int RETRY_DELAY_US  = 10;
  // least time, so round the cycle count up
  localparam int RETRY_DELAY_CYC =
    (RETRY_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // =========================================================================
  // widths
  localparam int DUR_W   = 16;
  localparam int RETRY_W = 4;
  localparam int TMR_W   = 11;
  localparam int SYNC_W  = 13;

  localparam logic [TMR_W-1:0] RETRY_LAST = TMR_W'(RETRY_DELAY_CYC - 1);
  localparam logic [DUR_W-1:0] DUR_MAX    = '1;

  // =========================================================================
  // synchroniser bit positions (two bits per channel field)
  localparam int SY_OT   = 0;
  localparam int SY_OCH  = 2;
  localparam int SY_OCM  = 4;
  localparam int SY_OCL  = 6;
  localparam int SY_SC   = 8;
  localparam int SY_PROF = 10;
  localparam int SY_OV   = 12;

  // =========================================================================
  // state types
  typedef enum logic [3:0] {
    WIN_IDLE   = 4'h1,
    WIN_FIRST  = 4'h2,
    WIN_SECOND = 4'h4,
    WIN_STEADY = 4'h8
  } win_t;

  typedef struct packed {
    logic              gate;
    logic              cmdPrev;
    logic              otHold;
    logic              otFlag;
    logic              ocFlag;
    logic              scFlag;
    logic              latched;
    logic              retryWait;
    logic              firstOnDone;
    logic              cleanOn;
    win_t              win;
    logic [DUR_W-1:0]  durCnt;
    logic [RETRY_W-1:0] retryCnt;
    logic [TMR_W-1:0]  retryTmr;
  } chan_t;

  typedef struct packed {
    chan_t [1:0] ch;
    logic        otPinLow;
    logic        ovFlag;
    logic        faultPin_n;
    logic        syncOut_n;
    logic [1:0]  senseEn;
  } fp_state_t;

  // =========================================================================
  // reset values
  localparam chan_t CHAN_RESET = '{win: WIN_IDLE, default: '0};
  localparam fp_state_t FP_RESET = '{
    ch: '{CHAN_RESET, CHAN_RESET},
    otPinLow: 1'b0, ovFlag: 1'b0, faultPin_n: 1'b1, syncOut_n: 1'b1,
    senseEn: 2'h0};

endpackage : hss_fault_pkg

// >>> rtl/fault_input_sync.sv
// three-stage synchroniser with agreement filter for comparator inputs
// assumes inputs are asynchronous to clk; output changes only when the
// second and third stages agree
`timescale 1ns/1ns
`default_nettype none
module fault_input_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  // =========================================================================
  // stage shift; first stage feeds only the second
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];  // a glitch seen in one stage is dropped
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.q;

endmodule : fault_input_sync
`default_nettype wire

// >>> rtl/hss_fault_protect.sv
// fault protection core for both channels of a dual high-side switch
// assumes control/read strobes come from logic on core_clk; comparator
// results and profile pins are asynchronous and synchronised here
//
// Overview of operation
// - overtemperature turns channel off, sets its flag, pulls fault pin low
// - after overtemperature, pin rises only on turn-on with no heat present
// - overtemperature is caught while off; pin low until cool and turn-on
// - with auto-retry the channel turns back on once it has cooled
// - temp flag clears on fault read only if cool and pin already high
// - overcurrent turns channel off, sets its flag, pulls fault pin low
// - overcurrent is a threshold crossing or a window outlasting its width
// - during a channel's window its sensing is blanked; sense sync high only when no channel senses
// - profile pin low selects lighting, high selects motor profile
// - lighting: three thresholds, two windows opened only at first turn-on
// - motor: one window opened whenever current passes the low threshold
// - motor: duration counter over window width trips overcurrent, then retry
// - with auto-retry, overcurrent latches only when retries run out
// - duration counter accumulates on-time only, ignoring off-times
// - delatch clears counter; lighting retries clear it, motor ones do not
// - motor: clean on-period clears counter at the following turn-off
// - in switch mode turn-offs never clear a motor counter; only delatch does
// - short at turn-on: immediate off, pin low, flag latched, may retry
// - enabled overvoltage turns both channels off, pin low, sets flag
// - overvoltage flag clears on status read once condition is gone
// - with protection disabled overvoltage only sets its warning flag
`timescale 1ns/1ns
`default_nettype none
module hss_fault_protect
  import hss_fault_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // asynchronous comparators and profile pins
  input  wire logic [1:0]       otDet,
  input  wire logic [1:0]       ocHighDet,
  input  wire logic [1:0]       ocMidDet,
  input  wire logic [1:0]       ocLowDet,
  input  wire logic [1:0]       scDet,
  input  wire logic             ovDet,
  input  wire logic [1:0]       loadProfileSelect,
  // channel control and configuration
  input  wire logic [1:0]       chanOnCmd,
  input  wire logic [1:0]       switchMode,
  input  wire logic [1:0]       autoRetryEn,
  input  wire logic [RETRY_W-1:0] retryLimit,
  input  wire logic [1:0]       delatchPulse,
  input  wire logic             overvoltageProtectDisable,
  input  wire logic [DUR_W-1:0] winWidthFirst,
  input  wire logic [DUR_W-1:0] winWidthSecond,
  // register read strobes
  input  wire logic [1:0]       faultRegRead,
  input  wire logic             statusRegRead,
  // outputs
  output logic [1:0]            chanGate,
  output logic                  faultStatusOut_n,
  output logic                  senseSync_n,
  output logic [1:0]            senseEnable,
  output logic [1:0]            overtempFlag,
  output logic [1:0]            overcurrentFlag,
  output logic [1:0]            shortCircuitFlag,
  output logic                  overvoltageFlag
);

  // =========================================================================
  // helpers
  function automatic logic inWindow(input win_t w);
    inWindow = (w == WIN_FIRST) || (w == WIN_SECOND);
  endfunction : inWindow

  // =========================================================================
  // input synchronisation
  logic [SYNC_W-1:0] syncQ;
  logic [1:0]        otS;
  logic [1:0]        ocH;
  logic [1:0]        ocM;
  logic [1:0]        ocL;
  logic [1:0]        scS;
  logic [1:0]        motor;
  logic              ovS;

  // every analog result enters through the filter before any decision
  fault_input_sync #(.W(SYNC_W)) u_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .din   ({ovDet, loadProfileSelect, scDet, ocLowDet, ocMidDet,
             ocHighDet, otDet}),
    .dout  (syncQ)
  );

  assign otS   = syncQ[SY_OT+:2];
  assign ocH   = syncQ[SY_OCH+:2];
  assign ocM   = syncQ[SY_OCM+:2];
  assign ocL   = syncQ[SY_OCL+:2];
  assign scS   = syncQ[SY_SC+:2];
  assign motor = syncQ[SY_PROF+:2];  // low = lighting, high = motor
  assign ovS   = syncQ[SY_OV];

  // =========================================================================
  // state
  fp_state_t  st_r;
  fp_state_t  st_nxt;
  logic [1:0] tripV;
  logic [1:0] scV;
  logic       ovBlock;

  assign ovBlock = ovS & ~overvoltageProtectDisable;

  // =========================================================================
  // next-state logic for both channels and the shared fault pin
  always_comb begin
    chan_t            ch;
    logic             rise;
    logic             expire;
    logic             gateNxt;
    logic             onEvent;
    logic             anyBusy;
    logic [DUR_W-1:0] width;
    ch      = CHAN_RESET;
    rise    = 1'b0;
    expire  = 1'b0;
    gateNxt = 1'b0;
    onEvent = 1'b0;
    anyBusy = 1'b0;
    width   = '0;
    tripV   = 2'h0;
    scV     = 2'h0;
    st_nxt  = st_r;
    for (int c = 0; c < 2; c++) begin
      ch   = st_r.ch[c];
      rise = chanOnCmd[c] & ~ch.cmdPrev;
      st_nxt.ch[c].cmdPrev = chanOnCmd[c];

      // window width follows the active segment
      width  = (ch.win == WIN_SECOND) ? winWidthSecond : winWidthFirst;
      expire = ch.gate && (ch.durCnt > width);

      // overcurrent profile stepping
      case (ch.win)
        WIN_IDLE: begin
          if (motor[c]) begin
            if (ch.gate && ocL[c]) begin
              st_nxt.ch[c].win = WIN_FIRST;  // event driven
            end
          end else if (ch.gate && !ch.firstOnDone) begin
            st_nxt.ch[c].win         = WIN_FIRST;  // once only
            st_nxt.ch[c].firstOnDone = 1'b1;
          end else if (ch.firstOnDone) begin
            st_nxt.ch[c].win = WIN_STEADY;
          end
        end
        WIN_FIRST: begin
          if (motor[c]) begin
            tripV[c] = (ch.gate && ocH[c]) || expire;
            if (!ocL[c]) begin
              st_nxt.ch[c].win = WIN_IDLE;
            end
          end else begin
            tripV[c] = ch.gate && ocH[c];
            if (expire) begin
              tripV[c] = tripV[c] || ocM[c];  // outlasted first window
              st_nxt.ch[c].win    = WIN_SECOND;
              st_nxt.ch[c].durCnt = '0;
            end
          end
        end
        WIN_SECOND: begin
          tripV[c] = (ch.gate && ocM[c]) || (expire && ocL[c]);
          if (expire) begin
            st_nxt.ch[c].win = WIN_STEADY;
          end
        end
        WIN_STEADY: begin
          tripV[c] = ch.gate && ocL[c];
          if (motor[c]) begin
            st_nxt.ch[c].win = WIN_IDLE;
          end
        end
        default: begin
          st_nxt.ch[c].win = WIN_IDLE;
        end
      endcase

      // only on-time inside a window counts; off-time freezes it
      if (ch.gate && inWindow(ch.win) && (ch.durCnt != DUR_MAX)
          && !(expire && !motor[c])) begin
        st_nxt.ch[c].durCnt = ch.durCnt + 1'b1;
      end

      // short at turn-on, reported by the comparator while driving
      scV[c] = ch.gate && scS[c];

      // flag clears on reads; sets below take priority
      if (faultRegRead[c] && !ch.latched && !ch.retryWait) begin
        st_nxt.ch[c].ocFlag = 1'b0;
        st_nxt.ch[c].scFlag = 1'b0;
      end
      if (faultRegRead[c] && !otS[c] && st_r.faultPin_n) begin
        st_nxt.ch[c].otFlag = 1'b0;
      end

      // retry wait and its timer
      if (ch.retryWait) begin
        st_nxt.ch[c].retryTmr = ch.retryTmr + 1'b1;
        if (ch.retryTmr == RETRY_LAST) begin
          st_nxt.ch[c].retryWait = 1'b0;
          st_nxt.ch[c].retryCnt  = ch.retryCnt + 1'b1;
          if (!motor[c]) begin
            st_nxt.ch[c].durCnt = '0;  // lighting retry restarts count
          end
        end
      end

      // delatch wipes latch, retries and counter; a trip in the same
      // cycle still wins so a live fault is never lost
      if (delatchPulse[c]) begin
        st_nxt.ch[c].latched   = 1'b0;
        st_nxt.ch[c].retryWait = 1'b0;
        st_nxt.ch[c].retryCnt  = '0;
        st_nxt.ch[c].durCnt    = '0;
      end
      // overcurrent or short: shut off, then retry or latch
      if (tripV[c] || scV[c]) begin
        st_nxt.ch[c].ocFlag  = ch.ocFlag | tripV[c];
        st_nxt.ch[c].scFlag  = ch.scFlag | scV[c];
        st_nxt.ch[c].cleanOn = 1'b0;
        if (autoRetryEn[c] && (ch.retryCnt < retryLimit)) begin
          st_nxt.ch[c].retryWait = 1'b1;
          st_nxt.ch[c].retryTmr  = '0;
        end else begin
          st_nxt.ch[c].latched   = 1'b1;  // retry disabled or retries used up
          st_nxt.ch[c].retryWait = 1'b0;
        end
      end

      // overtemperature hold and release
      if (otS[c]) begin
        st_nxt.ch[c].otFlag = 1'b1;
        st_nxt.ch[c].otHold = 1'b1;
      end else if (ch.otHold && (autoRetryEn[c] || rise)) begin
        st_nxt.ch[c].otHold = 1'b0;
      end

      // gate drive
      gateNxt = chanOnCmd[c] && !otS[c] && !st_nxt.ch[c].otHold
                && !st_nxt.ch[c].latched && !st_nxt.ch[c].retryWait
                && !ovBlock && !tripV[c] && !scV[c];
      st_nxt.ch[c].gate = gateNxt;
      if (gateNxt && !ch.gate) begin
        onEvent              = 1'b1;
        st_nxt.ch[c].cleanOn = 1'b1;
      end

      // motor counter reset at turn-off after a clean on-period; pwm
      // edges in switch mode must not erase the accumulated time
      if (!gateNxt && ch.gate && motor[c] && st_nxt.ch[c].cleanOn
          && !switchMode[c]) begin
        st_nxt.ch[c].durCnt = '0;
      end

      anyBusy = anyBusy | st_nxt.ch[c].latched | st_nxt.ch[c].retryWait;
      st_nxt.senseEn[c] = gateNxt && !inWindow(st_nxt.ch[c].win);
    end

    // shared overtemperature pin hold: set while hot, cleared by turn-on
    if (|otS) begin
      st_nxt.otPinLow = 1'b1;
    end else if (onEvent) begin
      st_nxt.otPinLow = 1'b0;
    end

    // overvoltage flag: warning even when protection is disabled
    if (statusRegRead && !ovS) begin
      st_nxt.ovFlag = 1'b0;
    end
    if (ovS) begin
      st_nxt.ovFlag = 1'b1;
    end

    st_nxt.faultPin_n = !(st_nxt.otPinLow || ovBlock || anyBusy);
    st_nxt.syncOut_n = !(|st_nxt.senseEn);  // high while no channel senses
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= FP_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // =========================================================================
  // outputs, all straight from the state register
  assign chanGate         = {st_r.ch[1].gate, st_r.ch[0].gate};
  assign faultStatusOut_n = st_r.faultPin_n;
  assign senseSync_n      = st_r.syncOut_n;
  assign senseEnable      = st_r.senseEn;
  assign overtempFlag     = {st_r.ch[1].otFlag, st_r.ch[0].otFlag};
  assign overcurrentFlag  = {st_r.ch[1].ocFlag, st_r.ch[0].ocFlag};
  assign shortCircuitFlag = {st_r.ch[1].scFlag, st_r.ch[0].scFlag};
  assign overvoltageFlag  = st_r.ovFlag;

  // =========================================================================
  // assertions
  // turn-on of either channel is what releases the shared heat hold
  logic onEventAny;
  assign onEventAny = |({st_nxt.ch[1].gate, st_nxt.ch[0].gate} & ~chanGate);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_ot_shutoff: assert property (
    otS[0] |=> !chanGate[0] && overtempFlag[0] && !faultStatusOut_n)
    else $error("overtemperature did not shut channel 0 off");

  a_ot_pin_hold: assert property (
    st_r.otPinLow && !onEventAny |=> !faultStatusOut_n)
    else $error("fault pin rose without a turn-on after overtemperature");

  a_ot_retry: assert property (
    st_r.ch[0].otHold && !otS[0] && autoRetryEn[0] |=> !st_r.ch[0].otHold)
    else $error("auto-retry did not release overtemperature hold");

  a_ot_flag_keep: assert property (
    overtempFlag[0] && (otS[0] || !faultStatusOut_n) |=> overtempFlag[0])
    else $error("overtemperature flag cleared too early");

  a_oc_shutoff: assert property (
    tripV[0] |=> !chanGate[0] && overcurrentFlag[0] && !faultStatusOut_n)
    else $error("overcurrent did not shut channel 0 off");

  a_sense_blank: assert property (
    inWindow(st_r.ch[0].win) |-> !senseEnable[0])
    else $error("sense enabled inside an overcurrent window");

  a_count_frozen: assert property (
    !chanGate[0] && !delatchPulse[0] && !st_r.ch[0].retryWait
    |=> $stable(st_r.ch[0].durCnt))
    else $error("duration counter moved while channel was off");

  a_retry_nolatch: assert property (
    tripV[0] && autoRetryEn[0] && (st_r.ch[0].retryCnt < retryLimit)
    |=> !st_r.ch[0].latched && st_r.ch[0].retryWait)
    else $error("overcurrent latched while retries remained");

  a_sc_latch: assert property (
    scV[0] && !autoRetryEn[0]
    |=> shortCircuitFlag[0] && st_r.ch[0].latched && !chanGate[0])
    else $error("short circuit not latched");

  a_ov_both_off: assert property (
    ovBlock |=> chanGate == 2'h0 && !faultStatusOut_n && overvoltageFlag)
    else $error("overvoltage did not turn both channels off");

  a_ov_warn_only: assert property (
    ovS && overvoltageProtectDisable |=> overvoltageFlag)
    else $error("overvoltage warning flag not set");

  c_lighting_first: cover property (
    !motor[0] && st_r.ch[0].win == WIN_FIRST ##1
    st_r.ch[0].win == WIN_SECOND);
  c_motor_trip: cover property (motor[0] && tripV[0]);
  c_retry_done: cover property (
    st_r.ch[0].retryWait ##1 !st_r.ch[0].retryWait && chanGate[0]);

endmodule : hss_fault_protect
`default_nettype wire

// >>> verif/mcu_model.sv
// far-side controller model: turns bench read requests into register reads
// assumes requests come from the bench on core_clk and are held >= 2 edges
`timescale 1ns/1ns
`default_nettype none
module mcu_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // requests from the bench
  input  wire logic [1:0] faultRdReq,
  input  wire logic       statusRdReq,
  // read strobes to the device
  output logic [1:0]      faultRegRead,
  output logic            statusRegRead
);
  logic [2:0] reqPrev_r;

  // =========================================================================
  // read strobes
  // edge detect so a held request reads once, as one serial frame would
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reqPrev_r     <= 3'h0;
      faultRegRead  <= 2'h0;
      statusRegRead <= 1'b0;
    end else begin
      reqPrev_r     <= {statusRdReq, faultRdReq};
      faultRegRead  <= faultRdReq & ~reqPrev_r[1:0];
      statusRegRead <= statusRdReq & ~reqPrev_r[2];
    end
  end
endmodule : mcu_model
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the switch fault protection core
// assumes the design's own assertions are live; reads go through mcu_model
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    checkCount++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("BAD %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb;
  import hss_fault_pkg::*;
  logic             core_clk, rst_n, ovDet, ovProtOff, statusRdReq;
  logic [1:0]       otDet, ocHighDet, ocLowDet, scDet, prof, chanOnCmd;
  logic [1:0]       ocMidDet, swMode;
  logic [1:0]       autoRetryEn, delatchPulse, faultRdReq, faultRegRead;
  logic [RETRY_W-1:0] retryLimit;
  logic [DUR_W-1:0] widthA, widthB;
  logic             statusRegRead, faultStatusOut_n, senseSync_n;
  logic             overvoltageFlag;
  logic [1:0]       chanGate, senseEnable, overtempFlag;
  logic [1:0]       overcurrentFlag, shortCircuitFlag;
  int               fails = 0;
  int               checkCount = 0;
  typedef struct packed {
    logic [1:0] on; logic [1:0] ot; logic ov; logic warn;
    logic [1:0] gate; logic pin; logic ovF;
  } row_t;
  // on, hot, over, disable -> gate, fault pin, volt flag
  row_t rows [5] = '{
    '{2'h3, 2'h0, 1'b0, 1'b0, 2'h3, 1'b1, 1'b0},
    '{2'h3, 2'h1, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0},
    '{2'h0, 2'h2, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0},
    '{2'h3, 2'h0, 1'b1, 1'b0, 2'h0, 1'b0, 1'b1},
    '{2'h3, 2'h0, 1'b1, 1'b1, 2'h3, 1'b1, 1'b1}};

  hss_fault_protect hss_fault_protect_i (
    .core_clk(core_clk), .rst_n(rst_n), .otDet(otDet),
    .ocHighDet(ocHighDet), .ocMidDet(ocMidDet), .ocLowDet(ocLowDet),
    .scDet(scDet), .ovDet(ovDet), .loadProfileSelect(prof),
    .chanOnCmd(chanOnCmd), .switchMode(swMode), .autoRetryEn(autoRetryEn),
    .retryLimit(retryLimit), .delatchPulse(delatchPulse),
    .overvoltageProtectDisable(ovProtOff), .winWidthFirst(widthA),
    .winWidthSecond(widthB), .faultRegRead(faultRegRead),
    .statusRegRead(statusRegRead), .chanGate(chanGate),
    .faultStatusOut_n(faultStatusOut_n), .senseSync_n(senseSync_n),
    .senseEnable(senseEnable), .overtempFlag(overtempFlag),
    .overcurrentFlag(overcurrentFlag), .shortCircuitFlag(shortCircuitFlag),
    .overvoltageFlag(overvoltageFlag));

  mcu_model mcu_model_i (
    .core_clk(core_clk), .rst_n(rst_n), .faultRdReq(faultRdReq),
    .statusRdReq(statusRdReq), .faultRegRead(faultRegRead),
    .statusRegRead(statusRegRead));

  // =========================================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // reset is held four edges so the input synchronisers flush too
  task automatic do_reset;
    @(posedge core_clk);
    rst_n <= 1'b0;
    {otDet, ocHighDet, ocLowDet, scDet, prof, chanOnCmd} <= '0;
    {autoRetryEn, delatchPulse, faultRdReq, ovDet, ovProtOff} <= '0;
    {statusRdReq, ocMidDet, swMode} <= '0;
    retryLimit <= '0;
    widthA <= 16'h0014;
    widthB <= 16'h000a;
    tick(4);
    rst_n <= 1'b1;
  endtask : do_reset

  // request held three edges: strobe lands on the second, then settles
  task automatic read_regs(input logic [1:0] f, input logic s);
    tick(1);
    faultRdReq <= f;
    statusRdReq <= s;
    tick(3);
    faultRdReq <= 2'h0;
    statusRdReq <= 1'b0;
    @(negedge core_clk);
  endtask : read_regs

  task automatic wait_gate0(input logic e, input int lim);
    int n;
    n = 0;
    while (chanGate[0] !== e && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_gate0

  task automatic finish_test;
    if (fails == 0 && checkCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // =========================================================================
  // clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // about 3100 cycles of work; over six times that means a hang
  initial begin
    #160000;
    fails++;
    finish_test();
  end

  // =========================================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    {otDet, ocHighDet, ocLowDet, scDet, prof, chanOnCmd} = '0;
    {autoRetryEn, delatchPulse, faultRdReq, ovDet, ovProtOff} = '0;
    {statusRdReq, retryLimit, widthA, widthB, ocMidDet, swMode} = '0;
    do_reset();
    tick(2);
    @(negedge core_clk);
    `CHK("reset gate", 2'h0, chanGate)
    `CHK("reset pin", 1'b1, faultStatusOut_n)
    `CHK("reset sync", 1'b1, senseSync_n)
    // table of plain heat and supply cases, fresh reset for each
    foreach (rows[i]) begin
      do_reset();
      chanOnCmd <= rows[i].on;
      otDet <= rows[i].ot;
      ovDet <= rows[i].ov;
      ovProtOff <= rows[i].warn;
      tick(10);
      @(negedge core_clk);
      `CHK("gate", rows[i].gate, chanGate)
      `CHK("fault pin", rows[i].pin, faultStatusOut_n)
      `CHK("volt flag", rows[i].ovF, overvoltageFlag)
    end
    // heat release needs a fresh turn-on; flag clear needs cool and pin up
    do_reset();
    chanOnCmd <= 2'h1;
    otDet <= 2'h1;
    tick(10);
    `CHK("hot flag", 2'h1, overtempFlag)
    read_regs(2'h1, 1'b0);
    `CHK("hot read", 2'h1, overtempFlag)
    tick(1);
    otDet <= 2'h0;
    tick(8);
    read_regs(2'h1, 1'b0);
    `CHK("pin low read", 2'h1, overtempFlag)
    `CHK("no release", 1'b0, faultStatusOut_n)
    tick(1);
    chanOnCmd <= 2'h0;
    tick(2);
    chanOnCmd <= 2'h1;
    tick(3);
    @(negedge core_clk);
    `CHK("re-on gate", 2'h1, chanGate)
    `CHK("re-on pin", 1'b1, faultStatusOut_n)
    read_regs(2'h1, 1'b0);
    `CHK("cool read", 2'h0, overtempFlag)
    // auto-retry turns a cooled channel back on
    do_reset();
    autoRetryEn <= 2'h1;
    chanOnCmd <= 2'h1;
    otDet <= 2'h1;
    tick(10);
    otDet <= 2'h0;
    wait_gate0(1'b1, 30);
    `CHK("heat retry", 2'h1, chanGate)
    // motor window: opens on low threshold, blanks, expires, delatch clears
    do_reset();
    prof <= 2'h1;
    chanOnCmd <= 2'h1;
    tick(8);
    @(negedge core_clk);
    `CHK("motor sensing", 1'b0, senseSync_n)
    tick(1);
    ocLowDet <= 2'h1;
    tick(8);
    @(negedge core_clk);
    `CHK("motor blank", 1'b1, senseSync_n)
    `CHK("early gate", 2'h1, chanGate)
    wait_gate0(1'b0, 40);
    `CHK("expiry gate", 2'h0, chanGate)
    `CHK("expiry flag", 2'h1, overcurrentFlag)
    `CHK("expiry pin", 1'b0, faultStatusOut_n)
    tick(1);
    ocLowDet <= 2'h0;
    tick(6);
    delatchPulse <= 2'h1;
    tick(1);
    delatchPulse <= 2'h0;
    ocLowDet <= 2'h1;
    tick(15);
    @(negedge core_clk);
    `CHK("fresh count", 2'h1, chanGate)
    // high threshold with one retry, then latched
    do_reset();
    prof <= 2'h1;
    autoRetryEn <= 2'h1;
    retryLimit <= 4'h1;
    chanOnCmd <= 2'h1;
    tick(3);
    {ocHighDet, ocLowDet} <= 4'hf;
    tick(10);
    `CHK("high trip", 2'h0, chanGate)
    wait_gate0(1'b1, 1300);
    `CHK("oc retry", 2'h1, chanGate)
    wait_gate0(1'b0, 20);
    tick(1400);
    @(negedge core_clk);
    `CHK("oc latched", 2'h0, chanGate)
    `CHK("latched pin", 1'b0, faultStatusOut_n)
    // lighting windows open at first turn-on only
    do_reset();
    chanOnCmd <= 2'h1;
    tick(4);
    @(negedge core_clk);
    `CHK("light blank", 1'b1, senseSync_n)
    tick(40);
    @(negedge core_clk);
    `CHK("light sense", 2'h1, senseEnable)
    tick(1);
    chanOnCmd <= 2'h0;
    tick(3);
    chanOnCmd <= 2'h1;
    tick(3);
    @(negedge core_clk);
    `CHK("no reopen", 1'b0, senseSync_n)
    // severe short while on
    do_reset();
    chanOnCmd <= 2'h1;
    tick(3);
    scDet <= 2'h1;
    tick(8);
    @(negedge core_clk);
    `CHK("short gate", 2'h0, chanGate)
    `CHK("short flag", 2'h1, shortCircuitFlag)
    `CHK("short pin", 1'b0, faultStatusOut_n)
    // a one-cycle comparator glitch is filtered out
    do_reset();
    otDet <= 2'h1;
    tick(1);
    otDet <= 2'h0;
    tick(8);
    @(negedge core_clk);
    `CHK("glitch flag", 2'h0, overtempFlag)
    // supply flag clears on status read only once the supply is back
    do_reset();
    ovProtOff <= 1'b1;
    ovDet <= 1'b1;
    tick(8);
    read_regs(2'h0, 1'b1);
    `CHK("ov held", 1'b1, overvoltageFlag)
    tick(1);
    ovDet <= 1'b0;
    tick(8);
    read_regs(2'h0, 1'b1);
    `CHK("ov cleared", 1'b0, overvoltageFlag)
    // mid threshold still exceeded when the first lighting window ends
    do_reset();
    ocMidDet <= 2'h1;
    chanOnCmd <= 2'h1;
    tick(30);
    @(negedge core_clk);
    `CHK("mid trip", 2'h1, overcurrentFlag)
    `CHK("mid gate", 2'h0, chanGate)
    // motor count survives a pwm off-time, a plain turn-off clears it
    for (int m = 0; m < 2; m++) begin
      do_reset();
      prof <= 2'h1;
      swMode <= 2'(m);
      ocLowDet <= 2'h1;
      chanOnCmd <= 2'h1;
      tick(18);
      chanOnCmd <= 2'h0;
      tick(2);
      chanOnCmd <= 2'h1;
      tick(14);
      @(negedge core_clk);
      `CHK("pwm count", 2'(m == 0), chanGate)
    end
    finish_test();
  end
endmodule : tb
`default_nettype wire
